// >>> verilog/rpsc_defines.vh
`ifndef RPSC_DEFINES_VH
`define RPSC_DEFINES_VH

// Preamble auto count in reference cycles
`define RPSC_PREAMBLE_CYCLES 6'h20
// Feedback divide ratios
`define RPSC_DIV_REF 3'h4
`define RPSC_DIV_DATA 3'h2
// Loop input select encodings
`define RPSC_SEL_REF 1'h0
`define RPSC_SEL_DATA 1'h1
// Restart hold length in system cycles
`define RPSC_RESTART_CYCLES 3'h2
// Register offsets (byte addresses)
`define RPSC_REG_CTRL 4'h0
`define RPSC_REG_STAT 4'h4
`define RPSC_REG_CNT 4'h8
// Control field positions
`define RPSC_CTRL_RD 0
`define RPSC_CTRL_HOLD 1
`define RPSC_CTRL_GSEL 2
`define RPSC_CTRL_PRE 3
// Bus responses
`define RPSC_RESP_OK 2'h0
`define RPSC_RESP_ERR 2'h2

`endif

// >>> verilog/rpsc_sync2.v
`timescale 1ns/1ps
`include "rpsc_defines.vh"

// Two flop synchroniser for pins from outside the clock domain
module rpsc_sync2 #(
  parameter W = 1
) (
  input wire i_sys_clk,
  input wire i_rst_b,
  input wire [W-1:0] i_d,
  output wire [W-1:0] o_q
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;

  // First stage feeds only the second
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
    end else begin
      s1_r <= i_d;
      s2_r <= s1_r;
    end
  end

  assign o_q = s2_r;
endmodule // rpsc_sync2

// >>> verilog/rpsc_axil.v
`timescale 1ns/1ps
`include "rpsc_defines.vh"

// AXI4-Lite slave, one outstanding write and read; reads answer in one cycle, writes one cycle later
module rpsc_axil (
  input wire i_sys_clk,
  input wire i_rst_b,
  input wire i_awvalid,
  output wire o_awready,
  input wire [3:0] i_awaddr,
  input wire i_wvalid,
  output wire o_wready,
  input wire [31:0] i_wdata,
  input wire [3:0] i_wstrb,
  output reg o_bvalid,
  input wire i_bready,
  output reg [1:0] o_bresp,
  input wire i_arvalid,
  output wire o_arready,
  input wire [3:0] i_araddr,
  output reg o_rvalid,
  input wire i_rready,
  output reg [31:0] o_rdata,
  output reg [1:0] o_rresp,
  output wire o_wr_en,
  output wire [3:0] o_wr_addr,
  output wire [31:0] o_wr_data,
  output wire [3:0] o_wr_strb,
  output wire [3:0] o_rd_addr,
  input wire [31:0] i_rd_data,
  input wire i_rd_ok,
  input wire i_wr_ok
);
  reg aw_r;
  reg w_r;
  reg [3:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  wire do_wr;

  // Address and data may come in either order; latch each
  assign o_awready = !aw_r && !o_bvalid;
  assign o_wready = !w_r && !o_bvalid;
  assign o_arready = !o_rvalid;
  assign do_wr = aw_r && w_r;
  assign o_wr_en = do_wr;
  assign o_wr_addr = awaddr_r;
  assign o_wr_data = wdata_r;
  assign o_wr_strb = wstrb_r;
  assign o_rd_addr = i_araddr;

  // Write channel capture and response
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      aw_r <= 1'b0;
      w_r <= 1'b0;
      awaddr_r <= 4'h0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      o_bvalid <= 1'b0;
      o_bresp <= `RPSC_RESP_OK;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_r <= 1'b1;
        awaddr_r <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_r <= 1'b1;
        wdata_r <= i_wdata;
        wstrb_r <= i_wstrb;
      end
      if (do_wr) begin
        aw_r <= 1'b0;
        w_r <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= i_wr_ok ? `RPSC_RESP_OK : `RPSC_RESP_ERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: data captured at address handshake
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rvalid <= 1'b0;
      o_rdata <= 32'h00000000;
      o_rresp <= `RPSC_RESP_OK;
    end else if (i_arvalid && o_arready) begin
      o_rvalid <= 1'b1;
      o_rdata <= i_rd_ok ? i_rd_data : 32'h00000000;
      o_rresp <= i_rd_ok ? `RPSC_RESP_OK : `RPSC_RESP_ERR;
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
    end
  end
endmodule // rpsc_axil

// >>> verilog/rpsc_top.v
`timescale 1ns/1ps
`include "rpsc_defines.vh"

module rpsc_top #(
  parameter CNT_W = 6,
  parameter [CNT_W-1:0] PREAMBLE_CYCLES = `RPSC_PREAMBLE_CYCLES
) (
  input wire i_sys_clk,
  input wire i_rst_b,
  // Pins from the controller and read channel
  input wire i_read_gate_b,
  input wire i_preamble_gain_hold,
  input wire i_gain_control_select,
  input wire i_low_rate_prescale_select,
  input wire i_reference_osc_input,
  input wire i_read_data,
  // AXI4-Lite slave
  input wire i_awvalid,
  output wire o_awready,
  input wire [3:0] i_awaddr,
  input wire i_wvalid,
  output wire o_wready,
  input wire [31:0] i_wdata,
  input wire [3:0] i_wstrb,
  output wire o_bvalid,
  input wire i_bready,
  output wire [1:0] o_bresp,
  input wire i_arvalid,
  output wire o_arready,
  input wire [3:0] i_araddr,
  output wire o_rvalid,
  input wire i_rready,
  output wire [31:0] o_rdata,
  output wire [1:0] o_rresp,
  // Loop control outputs
  output reg o_loop_input_select,
  output reg o_high_gain,
  output reg [2:0] o_feedback_div,
  output reg o_prescale_div2,
  output reg o_phase_only,
  output reg o_osc_halt,
  output reg o_sync_out_enable,
  output reg o_compare_enable,
  output reg o_delayed_data
);
  // One-hot states
  localparam [4:0] ST_REF = 5'h01;
  localparam [4:0] ST_WAIT = 5'h02;
  localparam [4:0] ST_RST_D = 5'h04;
  localparam [4:0] ST_PRE = 5'h08;
  localparam [4:0] ST_DATA = 5'h10;

  reg rst_s1_r;
  reg rst_b_r;
  wire rst_b;
  wire [3:0] pins_s;
  wire ref_s;
  wire dat_s;
  reg ref_d_r;
  reg dat_d_r;
  reg dat_pend_r;
  wire ref_rise;
  wire dat_rise;
  reg [4:0] state_r;
  reg [4:0] state_nxt;
  reg [CNT_W-1:0] pre_cnt_r;
  reg [2:0] hold_cnt_r;
  reg rst_ref_r;
  reg pulse_seen_r;
  reg [3:0] ctrl_r;
  wire reading;
  wire hold_src;
  wire gsel_src;
  wire pre_src;
  wire pre_done;
  wire auto_hold;
  wire gain_hi_data;
  wire wr_en;
  wire [3:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire [3:0] rd_addr;
  reg [31:0] rd_data;
  reg rd_ok;

  // Address decode shared by read and write paths
  function addr_ok;
    input [3:0] a;
    begin
      addr_ok = (a == `RPSC_REG_CTRL) || (a == `RPSC_REG_STAT) ||
        (a == `RPSC_REG_CNT);
    end
  endfunction

  // Reset release through two flops
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_s1_r <= 1'b0;
      rst_b_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_b_r <= rst_s1_r;
    end
  end
  assign rst_b = rst_b_r;

  // Control pins are asynchronous; gate resets to idle (high)
  rpsc_sync2 #(.W(4)) u_pin_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(rst_b),
    .i_d({~i_read_gate_b, i_preamble_gain_hold, i_gain_control_select,
      i_low_rate_prescale_select}),
    .o_q(pins_s)
  );

  // Fast inputs; a real part samples these at full speed
  rpsc_sync2 #(.W(2)) u_fast_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(rst_b),
    .i_d({i_reference_osc_input, i_read_data}),
    .o_q({ref_s, dat_s})
  );

  // Software may override pins when its own control bit is set
  assign reading = pins_s[3] | ctrl_r[`RPSC_CTRL_RD];
  assign hold_src = pins_s[2] | ctrl_r[`RPSC_CTRL_HOLD];
  assign gsel_src = pins_s[1] | ctrl_r[`RPSC_CTRL_GSEL];
  assign pre_src = pins_s[0] | ctrl_r[`RPSC_CTRL_PRE];

  // Edge detection; a data rise is held until the next reference edge so
  // pulses shorter than half a reference period are not lost
  always @(posedge i_sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_d_r <= 1'b0;
      dat_d_r <= 1'b0;
      dat_pend_r <= 1'b0;
    end else begin
      ref_d_r <= ref_s;
      dat_d_r <= dat_s;
      // A rise on the clearing edge goes straight to the output instead
      if (ref_s != ref_d_r) begin
        dat_pend_r <= 1'b0;
      end else if (dat_rise) begin
        dat_pend_r <= 1'b1;
      end
    end
  end
  assign ref_rise = ref_s & ~ref_d_r;
  assign dat_rise = dat_s & ~dat_d_r;

  // Auto count ends preamble; gain hold pin ends it when selected
  assign pre_done = (pre_cnt_r >= PREAMBLE_CYCLES);
  assign auto_hold = ~pre_done;
  assign gain_hi_data = gsel_src ? hold_src : auto_hold;

  // Preamble counter, cleared whenever the gate pin and the software read bit are both off
  always @(posedge i_sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_cnt_r <= {CNT_W{1'b0}};
    end else if (!reading) begin
      pre_cnt_r <= {CNT_W{1'b0}};
    end else if (ref_rise && !pre_done) begin
      pre_cnt_r <= pre_cnt_r + 1'b1;
    end
  end

  // Sequencer: next state
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_REF: begin
        if (reading) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!reading) begin
          state_nxt = ST_REF;
        end else if (dat_rise) begin
          state_nxt = ST_RST_D;
        end
      end
      ST_RST_D: begin
        if (hold_cnt_r == 3'h0) begin
          state_nxt = rst_ref_r ? ST_REF : ST_PRE;
        end
      end
      ST_PRE: begin
        if (!reading) begin
          state_nxt = ST_RST_D;
        end else if (!gain_hi_data) begin
          state_nxt = ST_DATA;
        end
      end
      ST_DATA: begin
        if (!reading) begin
          state_nxt = ST_RST_D;
        end
      end
      default: begin
        state_nxt = ST_REF;
      end
    endcase
  end

  // Sequencer registers and restart hold timer
  always @(posedge i_sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_REF;
      hold_cnt_r <= 3'h0;
      rst_ref_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r != ST_RST_D && state_nxt == ST_RST_D) begin
        hold_cnt_r <= `RPSC_RESTART_CYCLES - 3'h1; // Zero is the last one
        rst_ref_r <= (state_r != ST_WAIT); // Leaving data goes to ref
      end else if (hold_cnt_r != 3'h0) begin
        hold_cnt_r <= hold_cnt_r - 3'h1;
      end
    end
  end

  // Phase mode waits for a data pulse before comparing
  always @(posedge i_sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pulse_seen_r <= 1'b0;
    end else if (state_r == ST_REF || state_r == ST_RST_D) begin
      pulse_seen_r <= 1'b0;
    end else if (dat_rise) begin
      pulse_seen_r <= 1'b1;
    end
  end

  // Registered loop controls decoded from state
  always @(posedge i_sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      o_loop_input_select <= `RPSC_SEL_REF;
      o_high_gain <= 1'b1;
      o_feedback_div <= `RPSC_DIV_REF;
      o_prescale_div2 <= 1'b0;
      o_phase_only <= 1'b0;
      o_osc_halt <= 1'b0;
      o_sync_out_enable <= 1'b0;
      o_compare_enable <= 1'b1;
      o_delayed_data <= 1'b0;
    end else begin
      o_prescale_div2 <= pre_src;
      // Data released on the next reference edge, at most half a period late
      if (ref_s != ref_d_r) begin
        o_delayed_data <= dat_pend_r | dat_rise;
      end
      o_osc_halt <= (state_nxt == ST_RST_D);
      // Outputs muted across restarts so no runt pulses escape
      o_sync_out_enable <= (state_nxt == ST_PRE) ||
        (state_nxt == ST_DATA);
      case (state_nxt)
        ST_PRE: begin
          o_loop_input_select <= `RPSC_SEL_DATA;
          o_high_gain <= 1'b1;
          o_feedback_div <= `RPSC_DIV_DATA;
          o_phase_only <= 1'b1;
          o_compare_enable <= pulse_seen_r | dat_rise;
        end
        ST_DATA: begin
          o_loop_input_select <= `RPSC_SEL_DATA;
          o_high_gain <= 1'b0;
          o_feedback_div <= `RPSC_DIV_DATA;
          o_phase_only <= 1'b1;
          o_compare_enable <= pulse_seen_r | dat_rise;
        end
        ST_RST_D: begin
          o_high_gain <= 1'b1; // High gain through every restart
          o_compare_enable <= 1'b0;
        end
        default: begin
          o_loop_input_select <= `RPSC_SEL_REF;
          o_high_gain <= 1'b1;
          o_feedback_div <= `RPSC_DIV_REF;
          o_phase_only <= 1'b0;
          o_compare_enable <= 1'b1;
        end
      endcase
    end
  end

  rpsc_axil u_axil (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(rst_b),
    .i_awvalid(i_awvalid),
    .o_awready(o_awready),
    .i_awaddr(i_awaddr),
    .i_wvalid(i_wvalid),
    .o_wready(o_wready),
    .i_wdata(i_wdata),
    .i_wstrb(i_wstrb),
    .o_bvalid(o_bvalid),
    .i_bready(i_bready),
    .o_bresp(o_bresp),
    .i_arvalid(i_arvalid),
    .o_arready(o_arready),
    .i_araddr(i_araddr),
    .o_rvalid(o_rvalid),
    .i_rready(i_rready),
    .o_rdata(o_rdata),
    .o_rresp(o_rresp),
    .o_wr_en(wr_en),
    .o_wr_addr(wr_addr),
    .o_wr_data(wr_data),
    .o_wr_strb(wr_strb),
    .o_rd_addr(rd_addr),
    .i_rd_data(rd_data),
    .i_rd_ok(rd_ok),
    .i_wr_ok(addr_ok(wr_addr))
  );

  // Control register, low byte lane only
  always @(posedge i_sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= 4'h0;
    end else if (wr_en && wr_addr == `RPSC_REG_CTRL && wr_strb[0]) begin
      ctrl_r <= wr_data[3:0];
    end
  end

  // Read mux: status shows state and live loop controls
  always @* begin
    rd_ok = addr_ok(rd_addr);
    rd_data = 32'h00000000;
    case (rd_addr)
      `RPSC_REG_CTRL: rd_data[3:0] = ctrl_r;
      `RPSC_REG_STAT: rd_data[15:0] = {3'h0, state_r, o_feedback_div,
        o_loop_input_select, o_high_gain, o_phase_only, o_osc_halt,
        o_prescale_div2};
      `RPSC_REG_CNT: rd_data[CNT_W-1:0] = pre_cnt_r;
      default: rd_data = 32'h00000000;
    endcase
  end
endmodule // rpsc_top

// >>> verification/rpsc_top_properties.sv
`timescale 1ns/1ps
`include "rpsc_defines.vh"

// Watches the loop control pins of the top module
module rpsc_top_properties #(
  parameter CNT_W = 6,
  parameter [CNT_W-1:0] PREAMBLE_CYCLES = `RPSC_PREAMBLE_CYCLES
) (
  input wire i_sys_clk,
  input wire i_rst_b,
  input wire i_read_gate_b,
  input wire i_preamble_gain_hold,
  input wire i_gain_control_select,
  input wire i_low_rate_prescale_select,
  input wire i_rready,
  input wire i_bready,
  input wire o_bvalid,
  input wire o_rvalid,
  input wire [31:0] o_rdata,
  input wire o_loop_input_select,
  input wire o_high_gain,
  input wire [2:0] o_feedback_div,
  input wire o_prescale_div2,
  input wire o_phase_only,
  input wire o_osc_halt,
  input wire o_sync_out_enable,
  input wire o_compare_enable
);
  // One domain; the pin reset masks every check
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  // Restart: two cycles of halt, then release
  sequence restart_hold;
    o_osc_halt [*2] ##1 !o_osc_halt;
  endsequence
  sequence halt_near;
    o_osc_halt || $past(o_osc_halt);
  endsequence

  // Steady modes, restart excluded
  wire on_ref = !o_loop_input_select && !o_osc_halt;
  wire on_dat = o_loop_input_select && !o_osc_halt;

  chk_ref_mode:
    assert property (on_ref |-> o_high_gain && !o_phase_only &&
      o_feedback_div == `RPSC_DIV_REF) else $error("ref mode wrong");
  chk_data_mode:
    assert property (on_dat |-> o_phase_only &&
      o_feedback_div == `RPSC_DIV_DATA) else $error("data mode wrong");
  chk_halt_len:
    assert property ($rose(o_osc_halt) |-> restart_hold)
      else $error("restart length wrong");
  chk_switch_in:
    assert property ($rose(o_loop_input_select) |-> halt_near)
      else $error("data switch without restart");
  chk_switch_out:
    assert property ($fell(o_loop_input_select) |-> halt_near)
      else $error("ref switch without restart");
  chk_quiet_restart:
    assert property (o_osc_halt |-> !o_sync_out_enable)
      else $error("sync output during restart");
  chk_pfd_compare:
    assert property (!o_phase_only && !o_osc_halt |-> o_compare_enable)
      else $error("compare blocked in pfd mode");
  chk_ext_low_gain:
    assert property ((on_dat && i_gain_control_select &&
      !i_preamble_gain_hold) [*5] |-> !o_high_gain)
      else $error("gain hold release ignored");
  chk_idle_ref:
    assert property (i_read_gate_b [*8] |-> !o_loop_input_select)
      else $error("not on reference while idle");
  chk_prescale_on:
    assert property (i_low_rate_prescale_select [*5] |-> o_prescale_div2)
      else $error("prescale not applied");
  chk_read_hold:
    assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read answer dropped");
  chk_write_hold:
    assert property (o_bvalid && !i_bready |=> o_bvalid)
      else $error("write answer dropped");
endmodule // rpsc_top_properties

bind rpsc_top rpsc_top_properties #(.CNT_W(CNT_W),
  .PREAMBLE_CYCLES(PREAMBLE_CYCLES)) rpsc_top_properties_i (.*);

// >>> verification/rpsc_ctrl_model.sv
`timescale 1ns/1ps

// Controller and pulse detector facing the block's pins
module rpsc_ctrl_model (
  input wire i_sys_clk,
  input wire i_gate_req,
  input wire i_data_on,
  output wire o_read_gate_b,
  output reg o_ref_osc = 1'b0,
  output reg o_read_data = 1'b0
);
  reg [1:0] ref_cnt_r = 2'h0;
  reg [1:0] dat_cnt_r = 2'h0;

  // Gate is active low and follows the request
  assign o_read_gate_b = ~i_gate_req;

  // Reference runs free at clk/8, also between reads
  always @(posedge i_sys_clk) begin
    ref_cnt_r <= ref_cnt_r + 2'h1;
    if (ref_cnt_r == 2'h3)
      o_ref_osc <= ~o_ref_osc;
  end

  // One pulse every four cycles while reading with data on, no gaps
  always @(posedge i_sys_clk) begin
    dat_cnt_r <= dat_cnt_r + 2'h1;
    o_read_data <= i_gate_req && i_data_on && (dat_cnt_r == 2'h0);
  end
endmodule // rpsc_ctrl_model

// >>> verification/rpsc_top_tb_top.sv
`timescale 1ns/1ps
`include "rpsc_defines.vh"

module rpsc_top_tb_top;
  logic i_sys_clk, i_rst_b, i_preamble_gain_hold;
  logic i_gain_control_select, i_low_rate_prescale_select;
  logic i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic [3:0] i_awaddr, i_araddr, i_wstrb;
  logic [31:0] i_wdata, rd;
  logic gate_req, data_on;
  logic [1:0] rs;
  wire i_read_gate_b, i_reference_osc_input, i_read_data;
  wire o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  wire [1:0] o_bresp, o_rresp;
  wire [31:0] o_rdata;
  wire o_loop_input_select, o_high_gain, o_prescale_div2, o_phase_only;
  wire o_osc_halt, o_sync_out_enable, o_compare_enable, o_delayed_data;
  wire [2:0] o_feedback_div;
  int err_count, cmp_count;

  // Model reference runs at clk/8, so the auto switch is this many cycles
  localparam int AUTO_CYC = `RPSC_PREAMBLE_CYCLES * 8;

  // Full preamble count so the automatic switch is timed as built
  rpsc_top rpsc_top_i (.*);
  rpsc_ctrl_model rpsc_ctrl_model_i (.i_sys_clk(i_sys_clk),
    .i_gate_req(gate_req), .i_data_on(data_on),
    .o_read_gate_b(i_read_gate_b), .o_ref_osc(i_reference_osc_input),
    .o_read_data(i_read_data));

  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk_val(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic chk_range(input string nm, input int lo, hi, g);
    cmp_count++;
    if (g < lo || g > hi) begin
      err_count++;
      $display("BAD %s exp %0d to %0d seen %0d", nm, lo, hi, g);
    end
  endtask

  // Every wait loop passes here, so none can hang
  task automatic guard(inout int c);
    c++;
    if (c > 300) begin
      err_count++;
      $display("BAD wait exp done seen timeout");
      wrap_up();
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge i_sys_clk);
    #1;
  endtask

  function automatic logic pick(input int k);
    case (k)
      0: return o_osc_halt;
      1: return o_loop_input_select;
      default: return o_high_gain;
    endcase
  endfunction

  task automatic wait_on(input int k, input logic v, output int c);
    c = 0;
    while (pick(k) !== v) begin
      tick(1);
      guard(c);
    end
  endtask

  // Response channel: ready rises only after valid is seen
  task automatic take(input bit rdc, output logic [1:0] r);
    int c;
    logic v, got;
    c = 0;
    got = 1'b0;
    while (!got) begin
      @(negedge i_sys_clk);
      v = rdc ? o_rvalid : o_bvalid;
      got = v && (rdc ? i_rready : i_bready);
      r = rdc ? o_rresp : o_bresp;
      rd = o_rdata;
      @(posedge i_sys_clk);
      if (rdc)
        i_rready <= v && !got;
      else
        i_bready <= v && !got;
      guard(c);
    end
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    int c;
    logic pa, pw, ta, tw;
    c = 0;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge i_sys_clk);
    i_awvalid <= 1'b1;
    i_awaddr <= a;
    i_wvalid <= 1'b1;
    i_wdata <= d;
    while (pa || pw) begin
      @(negedge i_sys_clk);
      ta = pa && o_awready;
      tw = pw && o_wready;
      @(posedge i_sys_clk);
      if (ta)
        i_awvalid <= 1'b0;
      if (tw)
        i_wvalid <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
      guard(c);
    end
    take(1'b0, rs);
  endtask

  task automatic axi_rd(input logic [3:0] a);
    int c;
    logic t;
    c = 0;
    t = 1'b0;
    @(posedge i_sys_clk);
    i_arvalid <= 1'b1;
    i_araddr <= a;
    while (!t) begin
      @(negedge i_sys_clk);
      t = o_arready;
      @(posedge i_sys_clk);
      guard(c);
    end
    i_arvalid <= 1'b0;
    take(1'b1, rs);
  endtask

  // Gate goes low one cycle after a reference rise
  task automatic gate_on();
    int c;
    c = 0;
    while (i_reference_osc_input !== 1'b0) begin
      tick(1);
      guard(c);
    end
    while (i_reference_osc_input !== 1'b1) begin
      tick(1);
      guard(c);
    end
    @(posedge i_sys_clk);
    gate_req <= 1'b1;
    #1;
  endtask

  task automatic read_end();
    int c;
    @(posedge i_sys_clk);
    gate_req <= 1'b0;
    wait_on(0, 1'b1, c);
    wait_on(0, 1'b0, c);
    tick(3);
    chk_val("idle sel", `RPSC_SEL_REF, o_loop_input_select);
    chk_val("idle div", `RPSC_DIV_REF, o_feedback_div);
    chk_val("idle gain", 1'h1, o_high_gain);
  endtask

  task automatic t_reset();
    chk_val("rst sel", `RPSC_SEL_REF, o_loop_input_select);
    chk_val("rst gain", 1'h1, o_high_gain);
    chk_val("rst div", `RPSC_DIV_REF, o_feedback_div);
    chk_val("rst phase", 1'h0, o_phase_only);
    chk_val("rst sync", 1'h0, o_sync_out_enable);
    chk_val("rst dly", 1'h0, o_delayed_data);
    $display("test reset done");
  endtask

  task automatic t_regs();
    axi_rd(`RPSC_REG_STAT);
    chk_val("stat", {19'h0, 5'h01, `RPSC_DIV_REF, 5'h08}, rd);
    chk_val("stat resp", `RPSC_RESP_OK, rs);
    // Forced read with no data pulses parks the sequencer in its wait state
    axi_wr(`RPSC_REG_CTRL, 32'h00000001);
    axi_rd(`RPSC_REG_STAT);
    chk_val("force rd", {19'h0, 5'h02, `RPSC_DIV_REF, 5'h08}, rd);
    axi_wr(`RPSC_REG_CTRL, 32'h00000008);
    tick(5);
    chk_val("force pre", 1'h1, o_prescale_div2);
    axi_wr(`RPSC_REG_CTRL, 32'h00000000);
    axi_rd(4'hC);
    chk_val("bad rd resp", `RPSC_RESP_ERR, rs);
    chk_val("bad rd data", 32'h00000000, rd);
    axi_wr(4'hC, 32'h0000000F);
    chk_val("bad wr resp", `RPSC_RESP_ERR, rs);
    $display("test regs done");
  endtask

  task automatic t_prescale();
    @(posedge i_sys_clk);
    i_low_rate_prescale_select <= 1'b1;
    tick(6);
    chk_val("pre on", 1'h1, o_prescale_div2);
    chk_val("pre sel", `RPSC_SEL_REF, o_loop_input_select);
    @(posedge i_sys_clk);
    i_low_rate_prescale_select <= 1'b0;
    tick(6);
    chk_val("pre off", 1'h0, o_prescale_div2);
    $display("test prescale done");
  endtask

  // Auto count: gain drops 32 reference periods after the gate
  task automatic t_auto();
    int c, n;
    @(posedge i_sys_clk);
    i_gain_control_select <= 1'b0;
    data_on <= 1'b1;
    gate_on();
    wait_on(0, 1'b1, n);
    wait_on(1, 1'b1, c);
    n += c;
    chk_val("pre gain", 1'h1, o_high_gain);
    chk_val("pre phase", 1'h1, o_phase_only);
    chk_val("pre div", `RPSC_DIV_DATA, o_feedback_div);
    chk_val("pre sync", 1'h1, o_sync_out_enable);
    wait_on(2, 1'b0, c);
    // Up to four extra cycles for pin synchronisers and output register
    chk_range("auto count", AUTO_CYC, AUTO_CYC + 4, n + c);
    tick(2);
    chk_val("dat div", `RPSC_DIV_DATA, o_feedback_div);
    chk_val("dat phase", 1'h1, o_phase_only);
    chk_val("dat gain", 1'h0, o_high_gain);
    read_end();
    $display("test auto done");
  endtask

  task automatic t_ext();
    int c;
    @(posedge i_sys_clk);
    i_gain_control_select <= 1'b1;
    i_preamble_gain_hold <= 1'b1;
    data_on <= 1'b0;
    gate_on();
    tick(20);
    chk_val("no data sel", `RPSC_SEL_REF, o_loop_input_select);
    chk_val("no data dly", 1'h0, o_delayed_data);
    @(posedge i_sys_clk);
    data_on <= 1'b1;
    wait_on(0, 1'b1, c);
    wait_on(1, 1'b1, c);
    tick(60);
    chk_val("held gain", 1'h1, o_high_gain);
    chk_val("compare", 1'h1, o_compare_enable);
    chk_val("data dly", 1'h1, o_delayed_data);
    @(posedge i_sys_clk);
    i_preamble_gain_hold <= 1'b0;
    wait_on(2, 1'b0, c);
    chk_range("hold release", 1, 6, c);
    read_end();
    $display("test ext done");
  endtask

  // Short read, then a full one must count from its own gate
  task automatic t_abort();
    @(posedge i_sys_clk);
    i_gain_control_select <= 1'b0;
    data_on <= 1'b1;
    gate_on();
    tick(14);
    read_end();
    $display("test abort done");
  endtask

  initial begin
    i_rst_b = 1'b0;
    {i_preamble_gain_hold, i_gain_control_select} = 2'h0;
    {i_low_rate_prescale_select, gate_req, data_on} = 3'h0;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
    {i_awaddr, i_araddr, i_wstrb, i_wdata} = {12'h00F, 32'h0};
    err_count = 0;
    cmp_count = 0;
    repeat (6) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    tick(6);
    t_reset();
    t_regs();
    t_prescale();
    t_auto();
    t_ext();
    t_abort();
    t_auto();
    wrap_up();
  end
endmodule // rpsc_top_tb_top
